// ===== design/fcsc_consts.vh
// Constants for the flash command and status controller.
`ifndef FCSC_CONSTS_VH
`define FCSC_CONSTS_VH
`define FCSC_IDX_CMD_INDEX   6'h02
`define FCSC_IDX_ERR_CONFIG  6'h04
`define FCSC_IDX_STATUS      6'h06
`define FCSC_IDX_ERR_STATUS  6'h07
`define FCSC_IDX_SECURITY    6'h09
`define FCSC_IDX_DATA_HIGH   6'h0a
`define FCSC_IDX_DATA_LOW    6'h0b
`define FCSC_ST_COMPLETE     7
`define FCSC_ST_ACCESS_ERR   5
`define FCSC_ST_PROT_VIOL    4
`define FCSC_ST_BUSY         3
`define FCSC_ST_MG1          1
`define FCSC_ST_MG0          0
`define FCSC_EF_CHANGE       3
`define FCSC_EF_FORMAT       2
`define FCSC_EF_DOUBLE       1
`define FCSC_EF_SINGLE       0
`define FCSC_CMD_VERIFY_ALL  8'h01
`define FCSC_CMD_VERIFY_SECT 8'h10
`define FCSC_VERIFY_ARGS     3'h2
`define FCSC_ERASED_WORD     16'hffff
`define FCSC_CFG_BASE        23'h7fff00
`define FCSC_CFG_LAST        3'h4
`define FCSC_ALL_WORDS       16'h0040
`define FCSC_DATA_PART_MAX   8'h80
`define FCSC_BUF_PART_MAX    8'h10
`define FCSC_SEC_UNSEC       2'h2
`define FCSC_DEF_PROT        8'h00
`define FCSC_DEF_OPTION      8'hff
`define FCSC_DEF_SECURITY    8'hff
`define FCSC_DEF_PART        16'h0000
`define FCSC_RST_BYTE        8'h00
`define FCSC_RST_WORD        16'h0000
`define FCSC_CLK_MHZ         40
`define FCSC_BUF_INIT_NS     1000
`define FCSC_BUF_INIT_CYC    ((`FCSC_BUF_INIT_NS * `FCSC_CLK_MHZ + 999) / 1000)
`endif

// ===== design/fcsc_top.v
// Command, status and error logic of the flash controller with its APB slave.
//
// Summary of operation
// - Clearing the complete flag launches the loaded erased check (verify-section or verify-all).
// - Complete flag sets again when the verify finishes.
// - Config bit 3 routes the change state error flag to the interrupt.
// - Config bit 2 routes the sector format error flag to the interrupt.
// - Config bit 1 routes the double fault flag to the interrupt.
// - Config bit 0 routes the single fault flag to the interrupt.
// - Status: complete, access and protection bits writable; busy, status read-only.
// - Launch with command index not equal to two (verify-section) or not zero (verify-all) sets access error.
// - Launch during an active load data field sequence sets access error.
// - Launch of a command not allowed in mode or security sets access error.
// - Launch with invalid partition sizes sets access error.
// - Any verify read error sets upper status; uncorrectable sets lower.
// - Every reset loads configuration, protections, option and security words.
// - Double faults during reset loading fall back to protected secured defaults.
// - Double fault during reset loading sets both controller status bits.
// - Buffer RAM initialization failure during reset sets access error.
// - Complete flag stays clear during init; first part stalls all access.
// - After the stall, command register writes are dropped while busy.
// - Init end sets complete flag and command writes become accepted.
// - Reset aborts any running command at once.
// - Verify-all in special mode with both arrays erased unsecures debug.
//
// Register access over APB was chosen for this implementation.
`include "fcsc_consts.vh"

module fcsc_top (
  input  wire        i_clock,
  input  wire        i_rstn,
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [7:0]  i_paddr,
  input  wire [31:0] i_pwdata,
  output reg  [31:0] o_prdata,
  output reg         o_pready,
  output reg         o_pslverr,
  output reg         o_rd_req,
  output reg  [22:0] o_rd_addr,
  input  wire        i_rd_valid,
  input  wire [15:0] i_rd_data,
  input  wire        i_rd_single_fault,
  input  wire        i_rd_double_fault,
  input  wire        i_load_field_active,
  input  wire        i_buffer_init_fail,
  input  wire        i_change_state_error,
  input  wire        i_sector_format_error,
  input  wire        i_special_mode,
  output reg         o_error_irq,
  output reg         o_busy,
  output reg         o_secured,
  output reg         o_debug_enable
);

  localparam S_IDLE   = 3'h0;
  localparam S_STALL  = 3'h1;
  localparam S_BUFINI = 3'h2;
  localparam S_VERIFY = 3'h3;

  // A set arriving with a clear wins, so no event is lost.
  function [7:0] flag_next;
    input [7:0] cur;
    input [7:0] set;
    input [7:0] clr;
    begin
      flag_next = set | (cur & ~clr);
    end
  endfunction

  reg  [2:0]  state;
  reg  [15:0] cnt;
  reg  [2:0]  command_index;
  reg  [15:0] ccob [0:5];
  reg  [7:0]  flash_error_config;
  reg  [7:0]  flash_error_status;
  reg         command_complete_flag;
  reg         access_error_flag;
  reg         protection_violation_flag;
  reg         controller_status_upper;
  reg         controller_status_lower;
  reg  [7:0]  program_flash_protection;
  reg  [7:0]  data_flash_protection;
  reg  [7:0]  option_register;
  reg  [7:0]  security_register;
  reg  [15:0] partition_word;
  reg         cfg_err;
  reg         verify_all;
  reg         not_clean;
  reg         unsecured;
  reg         mode_s1;
  reg         mode_s2;
  reg         mode_s3;
  reg         special_mode;
  reg  [31:0] rdata_mux;
  reg         slverr_mux;
  reg         launch_err;

  wire        stall      = (state == S_STALL);
  wire        access     = i_psel & i_penable & ~o_pready & ~stall;
  wire        wr_acc     = access & i_pwrite;
  wire [5:0]  widx       = i_paddr[7:2];
  wire        stat_wr    = wr_acc & (widx == `FCSC_IDX_STATUS);
  wire        estat_wr   = wr_acc & (widx == `FCSC_IDX_ERR_STATUS);
  wire        busy       = (state != S_IDLE);
  wire        secured    = (security_register[1:0] != `FCSC_SEC_UNSEC) & ~unsecured;
  wire [7:0]  cmd_code   = ccob[0][15:8];
  wire [7:0]  df_part    = partition_word[15:8];
  wire [7:0]  er_part    = partition_word[7:0];
  wire        rd_done    = o_rd_req & i_rd_valid;
  wire        fault_any  = i_rd_single_fault | i_rd_double_fault;
  wire        launch     = stat_wr & i_pwdata[`FCSC_ST_COMPLETE] & command_complete_flag & ~busy;
  wire        cmd_wr_ok  = wr_acc & command_complete_flag & ~busy;
  wire        last_word  = (cnt == ccob[2] - 16'h0001);
  // The fill time is fixed in nanoseconds, so its cycle count follows the clock rate.
  wire [31:0] buf_last   = `FCSC_BUF_INIT_CYC - 1;
  wire        buf_done   = (cnt == buf_last[15:0]);
  wire        buf_fail   = (state == S_BUFINI) & buf_done & i_buffer_init_fail;
  wire [7:0]  ef_set;
  wire [7:0]  ef_clr;

  assign ef_set = {4'h0, i_change_state_error, i_sector_format_error,
                   rd_done & (state == S_VERIFY) & i_rd_double_fault,
                   rd_done & (state == S_VERIFY) & i_rd_single_fault};
  assign ef_clr = estat_wr ? i_pwdata[7:0] : 8'h00;

  always @* begin
    launch_err = 1'b0;
    if (cmd_code == `FCSC_CMD_VERIFY_SECT) begin
      if (command_index != `FCSC_VERIFY_ARGS || ccob[2] == `FCSC_RST_WORD)
        launch_err = 1'b1;
      if (secured & ~special_mode)
        launch_err = 1'b1;
    end else if (cmd_code == `FCSC_CMD_VERIFY_ALL) begin
      if (command_index != 3'h0)
        launch_err = 1'b1;
    end else begin
      launch_err = 1'b1;
    end
    if (i_load_field_active)
      launch_err = 1'b1;
    if (df_part > `FCSC_DATA_PART_MAX || er_part > `FCSC_BUF_PART_MAX)
      launch_err = 1'b1;
  end

  always @* begin
    rdata_mux  = 32'h00000000;
    slverr_mux = 1'b0;
    case (widx)
      `FCSC_IDX_CMD_INDEX:  rdata_mux = {29'h00000000, command_index};
      `FCSC_IDX_ERR_CONFIG: rdata_mux = {24'h000000, flash_error_config};
      `FCSC_IDX_STATUS:     rdata_mux = {24'h000000, command_complete_flag, 1'b0,
                                          access_error_flag, protection_violation_flag, busy,
                                          1'b0, controller_status_upper, controller_status_lower};
      `FCSC_IDX_ERR_STATUS: rdata_mux = {24'h000000, flash_error_status};
      `FCSC_IDX_SECURITY:   rdata_mux = {24'h000000, security_register};
      `FCSC_IDX_DATA_HIGH:  rdata_mux = {24'h000000, ccob[command_index][15:8]};
      `FCSC_IDX_DATA_LOW:   rdata_mux = {24'h000000, ccob[command_index][7:0]};
      default:              slverr_mux = 1'b1;
    endcase
  end

  // The mode pin is asynchronous; a change counts once the last two stages agree.
  always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      mode_s1      <= 1'b0;
      mode_s2      <= 1'b0;
      mode_s3      <= 1'b0;
      special_mode <= 1'b0;
    end else begin
      mode_s1 <= i_special_mode;
      mode_s2 <= mode_s1;
      mode_s3 <= mode_s2;
      if (mode_s2 == mode_s3)
        special_mode <= mode_s3;
    end
  end

  always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      state                     <= S_STALL;
      cnt                       <= `FCSC_RST_WORD;
      command_index             <= 3'h0;
      ccob[0]                   <= `FCSC_RST_WORD;
      ccob[1]                   <= `FCSC_RST_WORD;
      ccob[2]                   <= `FCSC_RST_WORD;
      ccob[3]                   <= `FCSC_RST_WORD;
      ccob[4]                   <= `FCSC_RST_WORD;
      ccob[5]                   <= `FCSC_RST_WORD;
      flash_error_config        <= `FCSC_RST_BYTE;
      flash_error_status        <= `FCSC_RST_BYTE;
      command_complete_flag     <= 1'b0;
      access_error_flag         <= 1'b0;
      protection_violation_flag <= 1'b0;
      controller_status_upper   <= 1'b0;
      controller_status_lower   <= 1'b0;
      program_flash_protection  <= `FCSC_DEF_PROT;
      data_flash_protection     <= `FCSC_DEF_PROT;
      option_register           <= `FCSC_DEF_OPTION;
      security_register         <= `FCSC_DEF_SECURITY;
      partition_word            <= `FCSC_DEF_PART;
      cfg_err                   <= 1'b0;
      verify_all                <= 1'b0;
      not_clean                 <= 1'b0;
      unsecured                 <= 1'b0;
      o_prdata                  <= 32'h00000000;
      o_pready                  <= 1'b0;
      o_pslverr                 <= 1'b0;
      o_rd_req                  <= 1'b0;
      o_rd_addr                 <= 23'h000000;
      o_error_irq               <= 1'b0;
      o_busy                    <= 1'b1;
      o_secured                 <= 1'b1;
      o_debug_enable            <= 1'b0;
    end else begin
      o_pready  <= access;
      o_pslverr <= access & slverr_mux;
      if (access && !i_pwrite)
        o_prdata <= rdata_mux;

      // Register writes; command words are locked until the controller is idle.
      if (cmd_wr_ok && widx == `FCSC_IDX_CMD_INDEX)
        command_index <= i_pwdata[2:0];
      if (cmd_wr_ok && widx == `FCSC_IDX_DATA_HIGH && command_index <= 3'h5)
        ccob[command_index][15:8] <= i_pwdata[7:0];
      if (cmd_wr_ok && widx == `FCSC_IDX_DATA_LOW && command_index <= 3'h5)
        ccob[command_index][7:0] <= i_pwdata[7:0];
      if (wr_acc && widx == `FCSC_IDX_ERR_CONFIG)
        flash_error_config <= {4'h0, i_pwdata[3:0]};
      flash_error_status <= flag_next(flash_error_status, ef_set, ef_clr);

      access_error_flag <= (launch & launch_err) | buf_fail |
                           (access_error_flag & ~(stat_wr & i_pwdata[`FCSC_ST_ACCESS_ERR]));
      protection_violation_flag <= protection_violation_flag &
                                   ~(stat_wr & i_pwdata[`FCSC_ST_PROT_VIOL]);

      o_error_irq    <= |(flash_error_status[3:0] & flash_error_config[3:0]);
      o_busy         <= busy;
      o_secured      <= secured;
      o_debug_enable <= ~secured;

      case (state)
        S_IDLE: begin
          if (launch) begin
            controller_status_upper <= 1'b0;
            controller_status_lower <= 1'b0;
            if (launch_err) begin
              command_complete_flag <= 1'b1;
            end else begin
              command_complete_flag <= 1'b0;
              verify_all            <= (cmd_code == `FCSC_CMD_VERIFY_ALL);
              not_clean             <= 1'b0;
              cnt                   <= `FCSC_RST_WORD;
              if (cmd_code == `FCSC_CMD_VERIFY_ALL) begin
                o_rd_addr <= 23'h000000;
                ccob[2]   <= `FCSC_ALL_WORDS;
              end else begin
                o_rd_addr <= {ccob[0][6:0], ccob[1]};
              end
              o_rd_req <= 1'b1;
              state    <= S_VERIFY;
            end
          end
        end
        S_STALL: begin
          if (!o_rd_req) begin
            o_rd_req  <= 1'b1;
            o_rd_addr <= `FCSC_CFG_BASE + {7'h00, cnt};
          end else if (i_rd_valid) begin
            o_rd_req <= 1'b0;
            case (cnt[2:0])
              3'h0:    program_flash_protection <= i_rd_data[7:0];
              3'h1:    data_flash_protection    <= i_rd_data[7:0];
              3'h2:    option_register          <= i_rd_data[7:0];
              3'h3:    security_register        <= i_rd_data[7:0];
              default: partition_word           <= i_rd_data;
            endcase
            if (i_rd_double_fault) begin
              controller_status_upper <= 1'b1;
              controller_status_lower <= 1'b1;
            end
            if (cnt[2:0] == `FCSC_CFG_LAST) begin
              cnt   <= `FCSC_RST_WORD;
              state <= S_BUFINI;
              if (cfg_err | i_rd_double_fault) begin
                program_flash_protection <= `FCSC_DEF_PROT;
                data_flash_protection    <= `FCSC_DEF_PROT;
                option_register          <= `FCSC_DEF_OPTION;
                security_register        <= `FCSC_DEF_SECURITY;
                partition_word           <= `FCSC_DEF_PART;
              end
            end else begin
              cnt     <= cnt + 16'h0001;
              cfg_err <= cfg_err | i_rd_double_fault;
            end
          end
        end
        S_BUFINI: begin
          if (buf_done) begin
            command_complete_flag <= 1'b1;
            state                 <= S_IDLE;
          end else begin
            cnt <= cnt + 16'h0001;
          end
        end
        S_VERIFY: begin
          if (rd_done) begin
            o_rd_req <= 1'b0;
            if (fault_any)
              controller_status_upper <= 1'b1;
            if (i_rd_double_fault || i_rd_data != `FCSC_ERASED_WORD)
              controller_status_lower <= 1'b1;
            if (last_word) begin
              command_complete_flag <= 1'b1;
              state                 <= S_IDLE;
              if (verify_all && special_mode && !not_clean && !fault_any &&
                  i_rd_data == `FCSC_ERASED_WORD)
                unsecured <= 1'b1;
            end else begin
              cnt <= cnt + 16'h0001;
            end
            if (fault_any || i_rd_data != `FCSC_ERASED_WORD)
              not_clean <= 1'b1;
          end else if (!o_rd_req) begin
            o_rd_req  <= 1'b1;
            o_rd_addr <= o_rd_addr + 23'h000001;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

endmodule // fcsc_top

// ===== testbench/fcsc_monitor.sv
// Assertion checker bound to the flash command and status controller.
`include "fcsc_consts.vh"
module fcsc_monitor (
  input wire logic        i_clock,
  input wire logic        i_rstn,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire logic        o_rd_req,
  input wire logic [22:0] o_rd_addr,
  input wire logic        i_rd_valid,
  input wire logic        o_error_irq,
  input wire logic        o_busy,
  input wire logic        o_secured,
  input wire logic        o_debug_enable
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rstn);
  logic [2:0] init_reads;
  // Counting fetched words tells the checks when the stall phase is over.
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn)
      init_reads <= 3'h0;
    else if (o_rd_req && i_rd_valid && init_reads < 3'h5)
      init_reads <= init_reads + 3'h1;
  end
  a_stall_no_ready: assert property (init_reads < 3'h5 |-> !o_pready)
    else $error("bus answered during the stall phase");
  a_init_busy: assert property (init_reads < 3'h5 |-> o_busy)
    else $error("controller idle before init loading ended");
  a_init_word_addr: assert property (o_rd_req && init_reads < 3'h5 |->
    o_rd_addr == `FCSC_CFG_BASE + {20'h0, init_reads})
    else $error("init read at wrong address");
  a_read_req_held: assert property (o_rd_req && !i_rd_valid |=> o_rd_req && $stable(o_rd_addr))
    else $error("read request dropped or moved before data came");
  a_read_next_word: assert property (o_rd_req && i_rd_valid ##1 !o_rd_req ##1 o_rd_req |->
    o_rd_addr == $past(o_rd_addr, 2) + 23'h1)
    else $error("read addresses not sequential");
  a_debug_follows: assert property (o_debug_enable == !o_secured)
    else $error("debug enable disagrees with security state");
  a_slverr_ready: assert property (o_pslverr |-> o_pready && $past(i_psel && i_penable))
    else $error("slave error outside an access");
  a_ready_single: assert property (o_pready |=> !o_pready)
    else $error("ready held longer than one cycle");
  c_launch_done: cover property ($fell(o_busy));
  c_slverr_seen: cover property (o_pslverr);
  c_irq_raised: cover property ($rose(o_error_irq));
endmodule // fcsc_monitor
bind fcsc_top fcsc_monitor u_mon (.i_clock, .i_rstn, .i_psel, .i_penable, .o_pready, .o_pslverr, .o_rd_req,
  .o_rd_addr, .i_rd_valid, .o_error_irq, .o_busy, .o_secured, .o_debug_enable);

// ===== testbench/fcsc_tb.sv
// Self-checking testbench for the flash command and status controller.
`include "fcsc_consts.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clock, i_rstn, i_psel, i_penable, i_pwrite, i_rd_valid, i_rd_single_fault, i_rd_double_fault;
  logic        i_load_field_active, i_buffer_init_fail, i_change_state_error, i_sector_format_error, i_special_mode;
  logic        o_pready, o_pslverr, o_rd_req, o_error_irq, o_busy, o_secured, o_debug_enable, sl;
  logic [7:0]  i_paddr;
  logic [31:0] i_pwdata, o_prdata, q;
  logic [15:0] i_rd_data;
  logic [15:0] cfg [0:4];
  logic [22:0] o_rd_addr, first_addr, fault_addr;
  logic [1:0]  fault_kind;
  int          errors, comparisons, cycles, nreads, mark;

  fcsc_top u_dut (.i_clock, .i_rstn, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready,
    .o_pslverr, .o_rd_req, .o_rd_addr, .i_rd_valid, .i_rd_data, .i_rd_single_fault, .i_rd_double_fault,
    .i_load_field_active, .i_buffer_init_fail, .i_change_state_error, .i_sector_format_error, .i_special_mode,
    .o_error_irq, .o_busy, .o_secured, .o_debug_enable);

  always #12.5 i_clock = ~i_clock;

  function automatic logic [15:0] word(input logic [22:0] a);
    logic [22:0] k;
    k = a - `FCSC_CFG_BASE;
    return (k < 23'h5) ? cfg[k[2:0]] : `FCSC_ERASED_WORD;
  endfunction

  // Flash array model; released data toggles so stale values never look valid.
  always @(posedge i_clock) begin
    i_rd_valid <= o_rd_req && !i_rd_valid;
    i_rd_data <= (o_rd_req && !i_rd_valid) ? word(o_rd_addr) : ~i_rd_data;
    i_rd_single_fault <= o_rd_req && !i_rd_valid && o_rd_addr == fault_addr && fault_kind[0];
    i_rd_double_fault <= o_rd_req && !i_rd_valid && o_rd_addr == fault_addr && fault_kind[1];
    if (o_rd_req && i_rd_valid) begin
      if (nreads == mark)
        first_addr <= o_rd_addr;
      nreads <= nreads + 1;
    end
  end

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 30000) begin
      errors++;
      print_verdict();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // The stall phase may hold an access for many cycles, so the wait is generous.
  task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    i_psel <= 1'b1;
    i_pwrite <= wr;
    i_paddr <= {idx, 2'b00};
    i_pwdata <= d;
    @(posedge i_clock);
    i_penable <= 1'b1;
    do begin
      @(posedge i_clock);
      n++;
    end while (o_pready !== 1'b1 && n < 400);
    if (n >= 400)
      errors++;
    q = o_prdata;
    sl = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    repeat (2) @(posedge i_clock);
  endtask

  task automatic rd(input logic [5:0] idx, input string name, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    check(name, q, exp);
  endtask

  task automatic cmd(input int n, input logic [15:0] w0, input logic [15:0] w1, input logic [15:0] w2);
    logic [15:0] w [3];
    w = '{w0, w1, w2};
    for (int i = 0; i < n; i++) begin
      apb(1'b1, `FCSC_IDX_CMD_INDEX, {29'h0, i[2:0]});
      apb(1'b1, `FCSC_IDX_DATA_HIGH, {24'h0, w[i][15:8]});
      apb(1'b1, `FCSC_IDX_DATA_LOW, {24'h0, w[i][7:0]});
    end
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (o_busy !== 1'b0 && n < 2000) begin
      @(posedge i_clock);
      n++;
    end
    if (n >= 2000)
      errors++;
  endtask

  task automatic run(input logic [7:0] exp, input string name);
    mark = nreads;
    apb(1'b1, `FCSC_IDX_STATUS, 32'h80);
    wait_idle();
    rd(`FCSC_IDX_STATUS, name, {24'h0, exp});
    apb(1'b1, `FCSC_IDX_STATUS, 32'h20);
  endtask

  task automatic do_reset();
    i_rstn <= 1'b0;
    repeat (4) @(posedge i_clock);
    check("busy in reset", o_busy, 1);
    check("read in reset", o_rd_req, 0);
    i_rstn <= 1'b1;
  endtask

  initial begin
    {i_clock, i_rstn, i_psel, i_penable, i_pwrite} = 5'h0;
    {i_load_field_active, i_buffer_init_fail, i_change_state_error, i_sector_format_error, i_special_mode} = 5'h0;
    i_paddr = 8'h0;
    i_pwdata = 32'h0;
    fault_addr = 23'h0;
    fault_kind = 2'h0;
    cfg = '{16'h0000, 16'h0000, 16'h00ff, 16'h00fe, 16'h0000};
    do_reset();
    rd(`FCSC_IDX_STATUS, "status in init", 32'h08);
    apb(1'b1, `FCSC_IDX_CMD_INDEX, 32'h3);
    wait_idle();
    rd(`FCSC_IDX_CMD_INDEX, "index write while busy", 32'h0);
    rd(`FCSC_IDX_STATUS, "status after init", 32'h80);
    check("secured after init", o_secured, 0);
    apb(1'b1, `FCSC_IDX_STATUS, 32'h5f);
    rd(`FCSC_IDX_STATUS, "status read only bits", 32'h80);
    apb(1'b0, 6'h3f, 32'h0);
    check("unmapped slverr", sl, 1);
    $display("test init done");
    cmd(3, 16'h1010, 16'h0020, 16'h0004);
    run(8'h80, "verify clean");
    check("verify reads", nreads - mark, 4);
    check("first address", {9'h0, first_addr}, 32'h100020);
    fault_addr = 23'h100022;
    for (int k = 1; k < 3; k++) begin
      fault_kind = k[1:0];
      cmd(3, 16'h1010, 16'h0020, 16'h0004);
      run((k == 1) ? 8'h82 : 8'h83, "verify fault");
    end
    fault_kind = 2'h0;
    $display("test verify done");
    i_change_state_error <= 1'b1;
    i_sector_format_error <= 1'b1;
    @(posedge i_clock);
    i_change_state_error <= 1'b0;
    i_sector_format_error <= 1'b0;
    rd(`FCSC_IDX_ERR_STATUS, "error flags", 32'hf);
    check("irq masked", o_error_irq, 0);
    for (int b = 0; b < 4; b++) begin
      apb(1'b1, `FCSC_IDX_ERR_CONFIG, 32'h1 << b);
      check("irq enabled", o_error_irq, 1);
      apb(1'b1, `FCSC_IDX_ERR_STATUS, 32'h1 << b);
      check("irq cleared", o_error_irq, 0);
    end
    $display("test irq done");
    cmd(2, 16'h1010, 16'h0020, 16'h0004);
    run(8'ha0, "index error");
    rd(`FCSC_IDX_STATUS, "access error cleared", 32'h80);
    i_load_field_active <= 1'b1;
    cmd(3, 16'h1010, 16'h0020, 16'h0004);
    run(8'ha0, "load field error");
    i_load_field_active <= 1'b0;
    cmd(3, 16'h1010, 16'h0000, 16'h0100);
    apb(1'b1, `FCSC_IDX_STATUS, 32'h80);
    $display("test errors done");
    fault_addr = 23'h7fff04;
    fault_kind = 2'h2;
    do_reset();
    wait_idle();
    rd(`FCSC_IDX_STATUS, "init double fault", 32'h83);
    check("fallback secured", o_secured, 1);
    fault_kind = 2'h0;
    cmd(3, 16'h1010, 16'h0020, 16'h0004);
    run(8'ha0, "secured launch");
    i_special_mode <= 1'b1;
    repeat (6) @(posedge i_clock);
    cmd(1, 16'h0100, 16'h0000, 16'h0000);
    run(8'h80, "verify all");
    check("unsecured", o_secured, 0);
    check("debug enabled", o_debug_enable, 1);
    $display("test security done");
    i_special_mode <= 1'b0;
    i_buffer_init_fail <= 1'b1;
    cfg[4] = 16'h8100;
    do_reset();
    wait_idle();
    i_buffer_init_fail <= 1'b0;
    rd(`FCSC_IDX_STATUS, "buffer init fail", 32'ha0);
    apb(1'b1, `FCSC_IDX_STATUS, 32'h20);
    cmd(3, 16'h1010, 16'h0020, 16'h0004);
    run(8'ha0, "partition error");
    $display("test partition done");
    print_verdict();
  end
endmodule // tb_top
